// >>> wid_core.sv
// wake-up and interrupt dispatch with apb registers
//
// Summary of operation
// - outcome per source depends on mode, global state, wake and irq enables.
// - tick overflow in idle, irq enabled, globals off: wake, next instruction.
// - tick overflow in green, irq enabled, globals on: branch to vector.
// - ext pin both enables in idle: wake, then next or vector by global state.
// - globals disabled before sleep: wake resumes after the sleep instruction.
// - globals enabled before sleep: wake with irq enabled takes the vector.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module wid_core #(
  parameter int unsigned AW = 12
) (
  // clock, reset, enable
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            ce,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [AW-1:0]   paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // core instruction strobes
  input  wire logic            sleep_instr,
  input  wire logic            global_irq_enable_instr,
  input  wire logic            global_irq_disable_instr,
  // source event pulses
  input  wire logic            ext_pin_evt,
  input  wire logic            port_change_evt,
  input  wire logic            tick_counter_ovf,
  input  wire logic            serial_rx_evt,
  input  wire logic            serial_is_slave,
  // to program sequencer
  output wid_pkg::wid_dispatch_t disp,
  output logic                 low_power,
  output logic                 irq
);
  // refuse an address bus too narrow for the register map
  if (AW < 12) begin : g_aw_check
    $error("wid_core: AW must be at least 12");
  end

  typedef enum {S_RUN, S_LOW} wid_state_t;

  // outcome of one source, mode and global state
  function automatic wid_pkg::wid_act_t resolve(
    input wid_pkg::wid_pmode_t m,
    input logic gie,
    input logic we,
    input logic ie);
    wid_pkg::wid_act_t a;
    a = wid_pkg::ACT_NONE;
    case (m)
      wid_pkg::PM_SLEEP, wid_pkg::PM_IDLE: begin
        if (!we) a = wid_pkg::ACT_NONE;
        else if (gie && ie) a = wid_pkg::ACT_WAKE_VEC;
        else a = wid_pkg::ACT_WAKE_NEXT;
      end
      wid_pkg::PM_GREEN, wid_pkg::PM_NORMAL: begin
        if (!ie) a = wid_pkg::ACT_NONE;
        else if (gie) a = wid_pkg::ACT_VEC;
        else a = wid_pkg::ACT_NEXT;
      end
      default: a = wid_pkg::ACT_NONE;
    endcase
    return a;
  endfunction

  // register and state flops
  logic [wid_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [wid_pkg::NSRC-1:0]   stat_q, stat_d;
  logic [wid_pkg::NSRC-1:0]   mask_q, mask_d;
  logic [31:0]                rdata_q, rdata_d;
  logic                       err_q, err_d;
  logic                       gie_q, gie_d;
  wid_state_t                 st_q, st_d;
  wid_pkg::wid_dispatch_t     disp_q, disp_d;
  wid_pkg::wid_act_t          last_q, last_d;

  // decode
  logic                       setup, acc_wr, hit;
  logic [11:0]                addr;
  wid_pkg::wid_pmode_t        mode_sel, mode_eff;
  wid_pkg::wid_src_cfg_t [wid_pkg::NSRC-1:0] cfg;
  logic [wid_pkg::NSRC-1:0]   evt;
  wid_pkg::wid_act_t [wid_pkg::NSRC-1:0]     act;
  logic [31:0]                state_word;

  assign addr     = paddr[11:0];
  assign setup    = psel && !penable;
  assign acc_wr   = psel && penable && pwrite;
  assign hit      = (addr == wid_pkg::ADDR_CTRL) || (addr == wid_pkg::ADDR_STAT)
                 || (addr == wid_pkg::ADDR_MASK) || (addr == wid_pkg::ADDR_STATE);
  assign mode_sel = wid_pkg::wid_pmode_t'(ctrl_q[wid_pkg::CTRL_MODE_LSB +: 2]);
  // awake, a low-power mode selection runs as normal mode
  assign mode_eff = (st_q == S_LOW) ? mode_sel
                  : ((mode_sel == wid_pkg::PM_GREEN) ? wid_pkg::PM_GREEN
                                                     : wid_pkg::PM_NORMAL);
  assign evt = {serial_rx_evt, tick_counter_ovf, port_change_evt, ext_pin_evt};

  // per-source enables; tick counter has no wake bit of its own
  always_comb begin
    cfg[wid_pkg::SRC_EXT].wake_en  = ctrl_q[wid_pkg::CTRL_EXT_WE];
    cfg[wid_pkg::SRC_EXT].irq_en   = ctrl_q[wid_pkg::CTRL_EXT_IE];
    cfg[wid_pkg::SRC_PORT].wake_en = ctrl_q[wid_pkg::CTRL_PORT_WE];
    cfg[wid_pkg::SRC_PORT].irq_en  = ctrl_q[wid_pkg::CTRL_PORT_IE];
    cfg[wid_pkg::SRC_TICK].wake_en = (mode_eff == wid_pkg::PM_IDLE)
                                   && ctrl_q[wid_pkg::CTRL_TICK_IE];
    cfg[wid_pkg::SRC_TICK].irq_en  = ctrl_q[wid_pkg::CTRL_TICK_IE];
    cfg[wid_pkg::SRC_SER].wake_en  = ctrl_q[wid_pkg::CTRL_SER_WE] && serial_is_slave;
    cfg[wid_pkg::SRC_SER].irq_en   = ctrl_q[wid_pkg::CTRL_SER_IE];
  end

  always_comb begin
    for (int i = 0; i < wid_pkg::NSRC; i++) begin
      act[i] = evt[i] ? resolve(mode_eff, gie_q, cfg[i].wake_en, cfg[i].irq_en)
                      : wid_pkg::ACT_NONE;
    end
  end

  assign state_word = {20'h00000, 2'b00, disp_q.src, 1'b0, last_q,
                       (st_q == S_LOW), gie_q, mode_sel};

  // dispatch and low-power sequence; lowest source index wins a tie
  always_comb begin
    st_d   = st_q;
    disp_d = '0;
    last_d = last_q;
    gie_d  = gie_q;
    // enable wins if both strobes land together
    if (global_irq_disable_instr) gie_d = 1'b0;
    if (global_irq_enable_instr) gie_d = 1'b1;
    case (st_q)
      S_RUN: begin
        if (sleep_instr && (mode_sel == wid_pkg::PM_SLEEP
                            || mode_sel == wid_pkg::PM_IDLE)) begin
          st_d = S_LOW;
        end else begin
          for (int i = wid_pkg::NSRC - 1; i >= 0; i--) begin
            if (act[i] != wid_pkg::ACT_NONE) begin
              last_d = act[i];
              disp_d.src = 2'(i);
              disp_d.take_vec = (act[i] == wid_pkg::ACT_VEC);
            end
          end
        end
      end
      S_LOW: begin
        for (int i = wid_pkg::NSRC - 1; i >= 0; i--) begin
          if (act[i] != wid_pkg::ACT_NONE) begin
            last_d = act[i];
            disp_d.src = 2'(i);
            disp_d.wake = 1'b1;
            disp_d.resume_next = (act[i] == wid_pkg::ACT_WAKE_NEXT);
            disp_d.take_vec = (act[i] == wid_pkg::ACT_WAKE_VEC);
          end
        end
        if (disp_d.wake) st_d = S_RUN;
      end
      default: st_d = S_RUN;
    endcase
  end

  // apb register next values
  always_comb begin
    ctrl_d  = ctrl_q;
    mask_d  = mask_q;
    stat_d  = stat_q;
    rdata_d = rdata_q;
    err_d   = err_q;
    if (acc_wr && addr == wid_pkg::ADDR_CTRL) ctrl_d = pwdata[wid_pkg::CTRL_W-1:0];
    if (acc_wr && addr == wid_pkg::ADDR_MASK) mask_d = pwdata[wid_pkg::NSRC-1:0];
    if (acc_wr && addr == wid_pkg::ADDR_STAT) stat_d = stat_q & ~pwdata[wid_pkg::NSRC-1:0];
    // new event beats a clear in the same cycle
    stat_d = stat_d | evt;
    if (setup) begin
      err_d = !hit;
      case (addr)
        wid_pkg::ADDR_CTRL:  rdata_d = {22'h000000, ctrl_q};
        wid_pkg::ADDR_STAT:  rdata_d = {28'h0000000, stat_q};
        wid_pkg::ADDR_MASK:  rdata_d = {28'h0000000, mask_q};
        wid_pkg::ADDR_STATE: rdata_d = state_word;
        default:             rdata_d = 32'h00000000;
      endcase
    end
  end

  // all state frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= wid_pkg::CTRL_RST;
      mask_q  <= wid_pkg::MASK_RST;
      stat_q  <= 4'h0;
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
      gie_q   <= 1'b0;
      st_q    <= S_RUN;
      disp_q  <= '0;
      last_q  <= wid_pkg::ACT_NONE;
    end else if (ce) begin
      ctrl_q  <= ctrl_d;
      mask_q  <= mask_d;
      stat_q  <= stat_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
      gie_q   <= gie_d;
      st_q    <= st_d;
      disp_q  <= disp_d;
      last_q  <= last_d;
    end
  end

  // outputs; zero-wait apb, data latched in setup
  assign prdata    = rdata_q;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && err_q;
  assign disp      = disp_q;
  assign low_power = (st_q == S_LOW);
  assign irq       = |(stat_q & mask_q);

  // helper terms for checks
  logic only_tick, idle_low, green_run;
  assign only_tick = tick_counter_ovf && !ext_pin_evt && !port_change_evt;
  assign idle_low  = (st_q == S_LOW) && (mode_sel == wid_pkg::PM_IDLE);
  assign green_run = (st_q == S_RUN) && (mode_sel == wid_pkg::PM_GREEN) && !sleep_instr;

  chk_idle_tick_next: assert property (@(posedge pclk) disable iff (!presetn)
    ce && idle_low && only_tick && ctrl_q[wid_pkg::CTRL_TICK_IE] && !gie_q
    |=> disp.wake && disp.resume_next && !disp.take_vec && disp.src == 2'd2)
    else $error("idle tick overflow did not wake to next instruction");

  chk_green_tick_vec: assert property (@(posedge pclk) disable iff (!presetn)
    ce && green_run && only_tick && ctrl_q[wid_pkg::CTRL_TICK_IE] && gie_q
    |=> disp.take_vec && !disp.wake && disp.src == 2'd2)
    else $error("green tick overflow did not take the vector");

  chk_ext_idle_wake: assert property (@(posedge pclk) disable iff (!presetn)
    ce && idle_low && ext_pin_evt && ctrl_q[wid_pkg::CTRL_EXT_WE]
    && ctrl_q[wid_pkg::CTRL_EXT_IE]
    |=> disp.wake && disp.src == 2'd0 && (disp.take_vec == $past(gie_q)))
    else $error("ext pin idle wake chose wrong continuation");

  chk_wake_next_gie: assert property (@(posedge pclk) disable iff (!presetn)
    disp.wake && !$past(gie_q) |-> disp.resume_next && !disp.take_vec)
    else $error("wake with globals off did not resume next");

  chk_wake_vec_gie: assert property (@(posedge pclk) disable iff (!presetn)
    disp.take_vec && disp.wake |-> $past(gie_q) && !disp.resume_next)
    else $error("wake to vector without globals on");

  // wake bit gates low wake; a later event may still wake legally
  chk_no_wake_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (st_q == S_LOW) && ext_pin_evt && !ctrl_q[wid_pkg::CTRL_EXT_WE]
    && !port_change_evt && !tick_counter_ovf && !serial_rx_evt
    |=> !disp.wake && low_power)
    else $error("source woke with its wake enable off");

  chk_wake_exits_low: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(disp.wake) |-> !low_power && $past(low_power))
    else $error("wake pulse without leaving low power");

  chk_sleep_tick: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (st_q == S_LOW) && (mode_sel == wid_pkg::PM_SLEEP) && only_tick
    && !serial_rx_evt |=> !disp.wake)
    else $error("tick overflow woke from sleep");

  chk_sticky_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tick_counter_ovf |=> stat_q[wid_pkg::SRC_TICK])
    else $error("tick overflow did not set its status bit");

  // unmasked status raises irq; a mask write in that cycle may hide it
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tick_counter_ovf && mask_q[wid_pkg::SRC_TICK]
    && !(acc_wr && addr == wid_pkg::ADDR_MASK) |=> irq)
    else $error("unmasked status did not raise the interrupt");

  cov_idle_wake_next: cover property (@(posedge pclk) disable iff (!presetn)
    disp.wake && disp.resume_next);
  cov_sleep_wake_vec: cover property (@(posedge pclk) disable iff (!presetn)
    disp.wake && disp.take_vec);
  cov_run_vec: cover property (@(posedge pclk) disable iff (!presetn)
    disp.take_vec && !disp.wake);
  cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);
endmodule

// >>> wid_pkg.sv
// constants and types for the wake-up and interrupt dispatch block
package wid_pkg;
  // source indices
  localparam int unsigned NSRC     = 4;
  localparam int unsigned SRC_EXT  = 0;
  localparam int unsigned SRC_PORT = 1;
  localparam int unsigned SRC_TICK = 2;
  localparam int unsigned SRC_SER  = 3;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_STAT  = 12'h004;
  localparam logic [11:0] ADDR_MASK  = 12'h008;
  localparam logic [11:0] ADDR_STATE = 12'h00c;
  // control register fields
  localparam int unsigned CTRL_EXT_WE   = 0;
  localparam int unsigned CTRL_EXT_IE   = 1;
  localparam int unsigned CTRL_PORT_WE  = 2;
  localparam int unsigned CTRL_PORT_IE  = 3;
  localparam int unsigned CTRL_TICK_IE  = 4;
  localparam int unsigned CTRL_SER_WE   = 5;
  localparam int unsigned CTRL_SER_IE   = 6;
  localparam int unsigned CTRL_MODE_LSB = 8;
  localparam int unsigned CTRL_W        = 10;
  // state register fields
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_GIE      = 2;
  localparam int unsigned ST_LOW      = 3;
  localparam int unsigned ST_ACT_LSB  = 4;
  localparam int unsigned ST_SRC_LSB  = 8;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [NSRC-1:0]   MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    PM_SLEEP, PM_IDLE, PM_GREEN, PM_NORMAL
  } wid_pmode_t;

  typedef enum logic [2:0] {
    ACT_NONE, ACT_NEXT, ACT_WAKE_NEXT, ACT_WAKE_VEC, ACT_VEC
  } wid_act_t;

  // one source's enable pair
  typedef struct packed {
    logic wake_en;
    logic irq_en;
  } wid_src_cfg_t;

  // what the program sequencer is told
  typedef struct packed {
    logic       wake;
    logic       resume_next;
    logic       take_vec;
    logic [1:0] src;
  } wid_dispatch_t;
endpackage

// >>> wid_seq_model.sv
// program sequencer model: issues sleep and global irq pulses, counts wake dispatches
`timescale 1ns/1ps
module wid_seq_model (
  // clock
  input  wire logic                   pclk,
  // instruction strobes to the block
  output logic                        sleep_instr,
  output logic                        global_irq_enable_instr,
  output logic                        global_irq_disable_instr,
  // dispatch from the block
  input  wire wid_pkg::wid_dispatch_t disp
);
  int n_wake = 0;

  initial begin
    sleep_instr = 1'h0;
    global_irq_enable_instr = 1'h0;
    global_irq_disable_instr = 1'h0;
  end

  always @(posedge pclk) begin
    if (disp.wake === 1'h1) n_wake <= n_wake + 1;
  end

  // one-cycle pulse, as the core would issue it
  task set_gie(input logic g);
    @(posedge pclk);
    global_irq_enable_instr  <= g;
    global_irq_disable_instr <= !g;
    @(posedge pclk);
    global_irq_enable_instr  <= 1'h0;
    global_irq_disable_instr <= 1'h0;
  endtask

  task do_sleep();
    @(posedge pclk);
    sleep_instr <= 1'h1;
    @(posedge pclk);
    sleep_instr <= 1'h0;
  endtask
endmodule

// >>> wakeup_interrupt_dispatch_tb.sv
// self-checking bench for the wake-up and interrupt dispatch block
`timescale 1ns/1ps
module wakeup_interrupt_dispatch_tb;
  logic                   pclk = 1'h0;
  logic                   presetn = 1'h0;
  logic                   ce = 1'h1;
  logic                   psel = 1'h0;
  logic                   penable = 1'h0;
  logic                   pwrite = 1'h0;
  logic                   serial_is_slave = 1'h0;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic [31:0]            rd;
  logic [31:0]            cv;
  logic                   pready;
  logic                   pslverr;
  logic                   er;
  logic                   low_power;
  logic                   irq;
  logic                   slp;
  logic                   gen;
  logic                   gdis;
  logic [3:0]             evt = 4'h0;
  logic [4:0]             sn;
  logic [4:0]             e;
  wid_pkg::wid_dispatch_t disp;
  int                     n_fail = 0;
  int                     num_checks = 0;
  int                     n_wakes = 0;

  always #25 pclk = ~pclk;

  wid_core wid_core_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_instr(slp), .global_irq_enable_instr(gen),
    .global_irq_disable_instr(gdis), .ext_pin_evt(evt[0]), .port_change_evt(evt[1]),
    .tick_counter_ovf(evt[2]), .serial_rx_evt(evt[3]), .serial_is_slave(serial_is_slave),
    .disp(disp), .low_power(low_power), .irq(irq));

  wid_seq_model wid_seq_model_i (.pclk(pclk), .sleep_instr(slp),
    .global_irq_enable_instr(gen), .global_irq_disable_instr(gdis), .disp(disp));

  task summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // apb transfer; waits on pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic err);
    int k;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    // a slave that never answers ends the run as a failure
    if (pready !== 1'h1) begin
      n_fail++;
      summarize();
    end
    r = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        x;
    apb(1'h1, a, d, r, x);
  endtask

  task do_reset();
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
  endtask

  // event pulse; dispatch seen one cycle later
  task fire(input int s, output logic [4:0] seen);
    @(posedge pclk);
    evt[s] <= 1'h1;
    @(posedge pclk);
    evt <= 4'h0;
    #1 seen = disp;
  endtask

  function automatic logic [31:0] ctrl_of(input int s, input int m, input logic we, ie);
    logic [31:0] v;
    v = 32'h0;
    v[wid_pkg::CTRL_MODE_LSB +: 2] = 2'(m);
    case (s)
      0: begin
        v[wid_pkg::CTRL_EXT_WE] = we;
        v[wid_pkg::CTRL_EXT_IE] = ie;
      end
      1: begin
        v[wid_pkg::CTRL_PORT_WE] = we;
        v[wid_pkg::CTRL_PORT_IE] = ie;
      end
      2: v[wid_pkg::CTRL_TICK_IE] = ie;
      default: begin
        v[wid_pkg::CTRL_SER_WE] = we;
        v[wid_pkg::CTRL_SER_IE] = ie;
      end
    endcase
    return v;
  endfunction

  // tick has no wake enable: idle wake rides on its irq enable
  function automatic logic [4:0] exp_disp(input int s, input int m, input logic g, we, ie);
    logic w;
    if (m < 2) begin
      w = (s == 2) ? (m == 1 && ie) : we;
      return w ? {1'h1, !(g && ie), g && ie, 2'(s)} : 5'h00;
    end
    return (g && ie) ? {3'h1, 2'(s)} : 5'h00;
  endfunction

  initial begin
    for (int s = 0; s < 4; s++) for (int m = 0; m < 4; m++)
      for (int g = 0; g < 2; g++) for (int c = 0; c < 4; c++) begin
        do_reset();
        cv = ctrl_of(s, m, c[1], c[0]);
        e = exp_disp(s, m, g[0], c[1], c[0]);
        serial_is_slave <= 1'h1;
        wr(wid_pkg::ADDR_CTRL, cv);
        apb(1'h0, wid_pkg::ADDR_CTRL, 32'h0, rd, er);
        check(rd, cv);
        wid_seq_model_i.set_gie(g[0]);
        if (m < 2) begin
          wid_seq_model_i.do_sleep();
          #1 check(low_power, 1'h1);
        end
        fire(s, sn);
        if (e[4]) n_wakes++;
        check((e[4:2] == 3'h0) ? {sn[4:2], 2'h0} : sn, e);
        check(low_power, m < 2 && !e[4]);
      end
    do_reset();
    serial_is_slave <= 1'h0;
    wr(wid_pkg::ADDR_CTRL, 32'h060);
    wid_seq_model_i.do_sleep();
    fire(3, sn);
    check(sn, 5'h00);
    check(low_power, 1'h1);
    // sticky status, mask, level irq, unmapped place
    do_reset();
    // last wake pulse is counted by the model one edge after it is seen
    check(wid_seq_model_i.n_wake, n_wakes);
    wr(wid_pkg::ADDR_CTRL, 32'h300);
    wid_seq_model_i.set_gie(1'h1);
    apb(1'h0, wid_pkg::ADDR_STATE, 32'h0, rd, er);
    check(rd & 32'h00f, 32'h7);
    wr(wid_pkg::ADDR_MASK, 32'h4);
    fire(2, sn);
    check(sn[4:2], 3'h0);
    check(irq, 1'h1);
    apb(1'h0, wid_pkg::ADDR_STAT, 32'h0, rd, er);
    check(rd, 32'h4);
    wr(wid_pkg::ADDR_MASK, 32'h0);
    #1 check(irq, 1'h0);
    wr(wid_pkg::ADDR_MASK, 32'h4);
    #1 check(irq, 1'h1);
    wr(wid_pkg::ADDR_STAT, 32'h4);
    #1 check(irq, 1'h0);
    apb(1'h0, wid_pkg::ADDR_STAT, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'h0, 12'h010, 32'h0, rd, er);
    check(er, 1'h1);
    check(rd, 32'h0);
    // ce low freezes every register, so this write is lost
    ce <= 1'h0;
    wr(wid_pkg::ADDR_MASK, 32'h0);
    ce <= 1'h1;
    apb(1'h0, wid_pkg::ADDR_MASK, 32'h0, rd, er);
    check(rd, 32'h4);
    summarize();
  end
endmodule
